// ### shared/asbla_pkg.sv
// Package for the host controller of the byte-lane asynchronous static memory
package asbla_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  // Speed grade 12 ns figures in picoseconds, power-up wait in microseconds
  localparam int CYCLE_TIME_PS = 12000;
  localparam int ADDRESS_ACCESS_TIME_PS = 12000;
  localparam int OUTPUT_DRIVE_ACCESS_TIME_PS = 6000;
  localparam int WRITE_DATA_SETUP_PS = 6000;
  localparam int WRITE_FLOAT_DELAY_PS = 6000;
  localparam int LANE_SELECT_TO_WRITE_END_PS = 8000;
  localparam int WRITE_PULSE_PS = 8000;
  localparam int DESELECT_POWERDOWN_TIME_PS = 12000;
  localparam int POWER_UP_WAIT_US = 100;

  // Least times round up to whole cycles
  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_CYC = cyc_up(ADDRESS_ACCESS_TIME_PS) + 1;
  localparam int WR_PULSE_A = cyc_up(WRITE_PULSE_PS);
  localparam int WR_PULSE_B = cyc_up(LANE_SELECT_TO_WRITE_END_PS);
  localparam int WR_PULSE_C =
    cyc_up(WRITE_FLOAT_DELAY_PS + WRITE_DATA_SETUP_PS);
  localparam int WR_PULSE_AB =
    (WR_PULSE_A > WR_PULSE_B) ? WR_PULSE_A : WR_PULSE_B;
  localparam int WRITE_CYC =
    (WR_PULSE_AB > WR_PULSE_C) ? WR_PULSE_AB : WR_PULSE_C;
  localparam int IDLE_CYC = cyc_up(CYCLE_TIME_PS - WRITE_DATA_SETUP_PS);
  localparam int POWER_UP_CYC = POWER_UP_WAIT_US * 1000000 / CLK_PERIOD_PS;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    ASBLA_RD,
    ASBLA_WR
  } asbla_op_t;

  // User request
  typedef struct packed {
    asbla_op_t         op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lane_en;
  } asbla_req_t;

  // Memory pins driven by the host, strobes active low
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              chip_sel_n;
    logic              out_en_n;
    logic              write_n;
    logic              low_byte_select_n;
    logic              high_byte_select_n;
  } asbla_pins_t;

endpackage

// ### core/asbla_host.sv
// Host controller driving the asynchronous static memory pins
`timescale 1ns/1ps

// Function
// - Write only while chip select, write strobe and a lane select are low.
// - Chip select, write strobe and lane selects low before a write starts.
// - First strobe to rise ends the write; data is held across that edge.
// - Strobe write with output enable low lasts float delay plus setup.
// - Write strobe stays high throughout every read.
// - Address is valid no later than chip select falling for a read.
// - Host waits 100 microseconds after power before first access.
// - Write data set up at least the data setup time before write end.
// - Lane select held low at least lane-to-write-end time before end.
// - Address stable through the write window, zero setup allowed.
module asbla_host
  import asbla_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // User request
  input  wire logic              req_valid,
  input  wire asbla_req_t        req,
  output logic                   req_ready,
  // Read answer
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  // Memory pins
  output asbla_pins_t            pins,
  output logic [DATA_W-1:0]      data_pins_o,
  output logic                   data_pins_oe_n,
  input  wire logic [DATA_W-1:0] data_pins_i
);

  // Counts must fit the sequencer counter
  if (POWER_UP_CYCLES < 1 || READ_CYC >= (1 << CNT_W) ||
      WRITE_CYC >= (1 << CNT_W) || IDLE_CYC >= (1 << CNT_W)) begin : g_bad_cnt
    $error("asbla_host: counts out of range");
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_POWER, S_IDLE, S_READ, S_WRITE, S_GAP
  } asbla_state_t;

  localparam int PW = 32;
  localparam logic [PW-1:0] PW_ONE = 32'h00000001;
  localparam logic [CNT_W-1:0] CNT_WIDTH_W = CNT_W'(WRITE_CYC);
  localparam logic [CNT_W-1:0] CNT_WIDTH_R = CNT_W'(READ_CYC);
  localparam logic [CNT_W-1:0] CNT_GAP = CNT_W'(IDLE_CYC);

  asbla_state_t      state_r, state_nxt;
  logic [PW-1:0]     pwr_cnt_r, pwr_cnt_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  asbla_pins_t       pins_r, pins_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic              ready_r, ready_nxt;
  logic              rdv_r, rdv_nxt;
  logic [DATA_W-1:0] rdd_r, rdd_nxt;

  // Idle bus: all strobes high, memory deselected and in standby
  function automatic asbla_pins_t idle_pins(input logic [ADDR_W-1:0] a);
    asbla_pins_t p;
    p = '{addr: a, chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
          low_byte_select_n: 1'b1, high_byte_select_n: 1'b1};
    return p;
  endfunction

  always_comb begin
    state_nxt   = state_r;
    pwr_cnt_nxt = pwr_cnt_r;
    cnt_nxt     = cnt_r;
    pins_nxt    = pins_r;
    dout_nxt    = dout_r;
    oe_n_nxt    = oe_n_r;
    ready_nxt   = 1'b0;
    rdv_nxt     = 1'b0;
    rdd_nxt     = rdd_r;
    case (state_r)
      S_POWER: begin
        // Hold off until the supply has settled
        if (pwr_cnt_r >= PW'(POWER_UP_CYCLES) - PW_ONE) begin
          state_nxt = S_IDLE;
          ready_nxt = 1'b1;
        end else begin
          pwr_cnt_nxt = pwr_cnt_r + PW_ONE;
        end
      end
      S_IDLE: begin
        ready_nxt = 1'b1;
        if (req_valid && req_ready) begin
          ready_nxt = 1'b0;
          // Address, strobes and lanes all change on one edge
          pins_nxt.addr = req.addr;
          pins_nxt.chip_sel_n = 1'b0;
          pins_nxt.low_byte_select_n = ~req.lane_en[0];
          pins_nxt.high_byte_select_n = ~req.lane_en[1];
          if (req.op == ASBLA_WR) begin
            // No lane chosen: no strobe, so no empty write pulse appears
            pins_nxt.write_n = ~|req.lane_en;
            pins_nxt.out_en_n = 1'b1;
            dout_nxt = req.wdata;
            oe_n_nxt = 1'b0;
            cnt_nxt = CNT_WIDTH_W;
            state_nxt = S_WRITE;
          end else begin
            pins_nxt.write_n = 1'b1;
            pins_nxt.out_en_n = 1'b0;
            oe_n_nxt = 1'b1;
            cnt_nxt = CNT_WIDTH_R;
            state_nxt = S_READ;
          end
        end
      end
      S_READ: begin
        cnt_nxt = cnt_r - CNT_ONE;
        if (cnt_r == CNT_ONE) begin
          // Sample only after the access time has passed
          rdd_nxt = data_pins_i;
          rdv_nxt = 1'b1;
          pins_nxt = idle_pins(pins_r.addr);
          cnt_nxt = CNT_GAP;
          state_nxt = S_GAP;
        end
      end
      S_WRITE: begin
        cnt_nxt = cnt_r - CNT_ONE;
        if (cnt_r == CNT_ONE) begin
          // All strobes rise together; data and address held one more
          // cycle, giving hold past the ending edge
          pins_nxt = idle_pins(pins_r.addr);
          cnt_nxt = CNT_GAP;
          state_nxt = S_GAP;
        end
      end
      S_GAP: begin
        oe_n_nxt = 1'b1;
        cnt_nxt = cnt_r - CNT_ONE;
        if (cnt_r == CNT_ONE) begin
          state_nxt = S_IDLE;
          ready_nxt = 1'b1;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r   <= S_POWER;
      pwr_cnt_r <= '0;
      cnt_r     <= CNT_ZERO;
      pins_r    <= '{addr: '0, chip_sel_n: 1'b1, out_en_n: 1'b1,
                     write_n: 1'b1, low_byte_select_n: 1'b1,
                     high_byte_select_n: 1'b1};
      dout_r    <= '0;
      oe_n_r    <= 1'b1;
      ready_r   <= 1'b0;
      rdv_r     <= 1'b0;
      rdd_r     <= '0;
    end else begin
      state_r   <= state_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
      cnt_r     <= cnt_nxt;
      pins_r    <= pins_nxt;
      dout_r    <= dout_nxt;
      oe_n_r    <= oe_n_nxt;
      ready_r   <= ready_nxt;
      rdv_r     <= rdv_nxt;
      rdd_r     <= rdd_nxt;
    end
  end

  assign req_ready      = ready_r;
  assign rd_valid       = rdv_r;
  assign rd_data        = rdd_r;
  assign pins           = pins_r;
  assign data_pins_o    = dout_r;
  assign data_pins_oe_n = oe_n_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence wr_start;
    !pins.chip_sel_n && !pins.write_n;
  endsequence

  // Strobe held low for the whole pulse, then released
  sequence wr_pulse;
    (!pins.write_n)[*3] ##1 pins.write_n;
  endsequence

  a_read_we_high: assert property (
    !pins.out_en_n |-> pins.write_n)
    else $error("write strobe low during read");

  a_host_drive_write: assert property (
    !data_pins_oe_n |-> pins.out_en_n)
    else $error("host drives data while memory output enabled");

  a_write_overlap: assert property (
    $fell(pins.write_n) |-> !pins.chip_sel_n &&
      !(pins.low_byte_select_n && pins.high_byte_select_n))
    else $error("write strobe without chip select and lane");

  a_write_width: assert property (
    $fell(pins.write_n) |-> wr_pulse)
    else $error("write pulse width wrong");

  a_data_hold: assert property (
    $rose(pins.write_n) |-> $stable(data_pins_o) && !data_pins_oe_n)
    else $error("write data not held at write end");

  a_addr_stable: assert property (
    wr_start ##1 !pins.write_n |-> $stable(pins.addr))
    else $error("address moved during write");

  a_joint_release: assert property (
    $rose(pins.write_n) |-> pins.chip_sel_n &&
      pins.low_byte_select_n && pins.high_byte_select_n)
    else $error("strobes did not end write together");

  a_read_sample: assert property (
    $fell(pins.out_en_n) |-> ##4 rd_valid)
    else $error("read sampled at wrong time");

  a_power_wait: assert property (
    state_r == S_POWER |-> pins.chip_sel_n)
    else $error("access during power-up wait");

endmodule

// ### bench/asbla_mem_model.sv
// Behavioural model of the byte-lane static memory on the host's pins
`timescale 1ns/1ps
module asbla_mem_model
  import asbla_pkg::*;
(
  // Clock, only to vary the floating pattern
  input  wire logic              ref_clk,
  // Pins from the host
  input  wire asbla_pins_t       pins,
  input  wire logic [DATA_W-1:0] data_pins_o,
  input  wire logic              data_pins_oe_n,
  // Resolved data wire
  output logic [DATA_W-1:0]      data_pins_i
);
  logic [DATA_W-1:0] mem [0:262143];
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] last_r;
  logic [1:0]        lane;
  logic              rd_on;
  logic              wr_on;

  assign lane  = ~{pins.high_byte_select_n, pins.low_byte_select_n};
  assign rd_on = !pins.chip_sel_n && !pins.out_en_n
                 && pins.write_n;
  assign wr_on = !pins.chip_sel_n && !pins.write_n;
  // Old data lingers until the access time runs out
  assign #12 word = mem[pins.addr];

  always @* begin
    if (wr_on && !data_pins_oe_n) begin
      if (lane[0]) mem[pins.addr][7:0] = data_pins_o[7:0];
      if (lane[1]) mem[pins.addr][15:8] = data_pins_o[15:8];
    end
  end

  // Floating lanes show the inverse of the last level, so stale data fails
  always_comb begin
    data_pins_i = ~last_r;
    if (!data_pins_oe_n) data_pins_i = data_pins_o;
    else if (rd_on) begin
      if (lane[0]) data_pins_i[7:0] = word[7:0];
      if (lane[1]) data_pins_i[15:8] = word[15:8];
    end
  end

  always_ff @(posedge ref_clk) last_r <= data_pins_i;
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top
  import asbla_pkg::*;
;
  localparam int PU = 4;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              req_valid = 1'b0;
  asbla_req_t        req = '0;
  logic              req_ready, rd_valid, data_pins_oe_n;
  logic [DATA_W-1:0] rd_data, data_pins_o, data_pins_i;
  asbla_pins_t       pins;
  int                bad_count = 0;
  int                num_checks = 0;
  // Reads carry the expected word in the data field
  asbla_req_t rows [10] = '{
    '{ASBLA_WR, 18'h00000, 16'h1234, 2'h3},
    '{ASBLA_RD, 18'h00000, 16'h1234, 2'h3},
    '{ASBLA_WR, 18'h00000, 16'hABCD, 2'h1},
    '{ASBLA_RD, 18'h00000, 16'h12CD, 2'h3},
    '{ASBLA_WR, 18'h00000, 16'h5678, 2'h2},
    '{ASBLA_RD, 18'h00000, 16'h56CD, 2'h2},
    '{ASBLA_WR, 18'h3FFFF, 16'hA5A5, 2'h3},
    '{ASBLA_WR, 18'h3FFFF, 16'h0000, 2'h0},
    '{ASBLA_RD, 18'h3FFFF, 16'hA5A5, 2'h1},
    '{ASBLA_RD, 18'h00000, 16'h56CD, 2'h3}
  };

  asbla_host #(.POWER_UP_CYCLES(PU)) u_asbla_host (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .pins(pins), .data_pins_o(data_pins_o),
    .data_pins_oe_n(data_pins_oe_n), .data_pins_i(data_pins_i));
  asbla_mem_model u_asbla_mem_model (.ref_clk(ref_clk), .pins(pins),
    .data_pins_o(data_pins_o), .data_pins_oe_n(data_pins_oe_n),
    .data_pins_i(data_pins_i));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Pin-level watch on every rising edge
  always @(posedge ref_clk) begin
    if (!sys_rst && !pins.out_en_n)
      `CHK("rd_no_drive", 1'b1, data_pins_oe_n && pins.write_n)
    if (!sys_rst && $fell(pins.write_n))
      `CHK("wr_start", 1'b0, pins.chip_sel_n)
    if (!sys_rst && $rose(pins.write_n))
      `CHK("wr_end", 2'h2, {pins.chip_sel_n, data_pins_oe_n})
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_edge(input logic ready_side, inout int t);
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while ((ready_side ? req_ready : rd_valid) !== 1'b1 && t < 50);
    if (t >= 50) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic do_op(input asbla_req_t r);
    int          t;
    logic [15:0] m;
    m = {{8{r.lane_en[1]}}, {8{r.lane_en[0]}}};
    req <= r;
    req_valid <= 1'b1;
    wait_edge(1'b1, t);
    req_valid <= 1'b0;
    if (r.op == ASBLA_RD) begin
      wait_edge(1'b0, t);
      `CHK("rd_late", 1'b1, t inside {[READ_CYC:READ_CYC+1]})
      `CHK("rd_data", r.wdata & m, rd_data & m)
    end
    // Let an edge pass so the next request is not set in this time step
    @(posedge ref_clk);
  endtask

  // Requests offered during reset must be refused
  task automatic power_up();
    int t;
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    `CHK("rst_ready", 1'b0, req_ready)
    sys_rst <= 1'b0;
    req_valid <= 1'b0;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
      if (req_ready !== 1'b1)
        `CHK("idle_cs", 1'b1, pins.chip_sel_n)
    end while (req_ready !== 1'b1 && t < 50);
    `CHK("pwr_wait", 1'b1, t >= PU && t < 50)
  endtask

  initial begin
    power_up();
    foreach (rows[i]) do_op(rows[i]);
    req <= '{ASBLA_WR, 18'h00000, 16'h0000, 2'h3};
    req_valid <= 1'b1;
    power_up();
    do_op(rows[9]);
    conclude();
  end
endmodule
